// >>> hw/sms_pkg.sv
// Constants, register map and carrier types for the serial port
package sms_pkg;

    localparam int SMS_ADDR_W = 3;
    localparam int SMS_DATA_W = 8;

    // Register offsets
    localparam logic [2:0] SMS_OFS_CTRL = 3'h0;
    localparam logic [2:0] SMS_OFS_STAT = 3'h1;
    localparam logic [2:0] SMS_OFS_DATA = 3'h2;
    localparam logic [2:0] SMS_OFS_PINS = 3'h3;
    localparam logic [2:0] SMS_OFS_PWR = 3'h4;

    // Control register fields
    localparam int SMS_CTRL_IRQ_EN = 7;
    localparam int SMS_CTRL_ENABLE = 6;
    localparam int SMS_CTRL_ORDER = 5;
    localparam int SMS_CTRL_MASTER = 4;
    localparam int SMS_CTRL_CPOL = 3;
    localparam int SMS_CTRL_CPHA = 2;
    localparam int SMS_CTRL_RATE_HI = 1;
    localparam int SMS_CTRL_RATE_LO = 0;

    // Status register fields
    localparam int SMS_STAT_DONE = 7;
    localparam int SMS_STAT_WRITE_COLLISION_FLAG = 6;
    localparam int SMS_STAT_DOUBLE = 0;

    // Pin control register fields
    localparam int SMS_PINS_MOSI_OE = 0;
    localparam int SMS_PINS_SCK_OE = 1;
    localparam int SMS_PINS_SS_OE = 2;
    localparam int SMS_PINS_MISO_OE = 3;
    localparam int SMS_PINS_SS_LEVEL = 4;

    // Power register field
    localparam int SMS_PWR_OFF = 0;

    // Reset values
    localparam logic [7:0] SMS_CTRL_RST = 8'h00;
    localparam logic [7:0] SMS_PINS_RST = 8'h10;
    localparam logic [7:0] SMS_DATA_RST = 8'h00;

    // Last bit index and last SCK edge index of a byte
    localparam logic [2:0] SMS_LAST_BIT = 3'h7;
    localparam logic [3:0] SMS_LAST_EDGE = 4'hf;

    // Least SCK phase the slave can see, in system cycles
    localparam int SMS_SCK_MIN_PHASE_CYC = 2;

    // SCK half period in system cycles, indexed by {double, rate}
    localparam logic [6:0] SMS_HALF_DIV [0:7] = '{
        7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20
    };

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sms_bus_req_s;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } sms_pin_in_s;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
        logic ss_n_o;
        logic ss_n_oe;
    } sms_pin_out_s;

    typedef enum logic [0:0] {
        SMS_IDLE = 1'b0,
        SMS_RUN = 1'b1
    } sms_mstate_e;

endpackage

// >>> hw/sms_port.sv
// Byte-wide serial port, master or slave, with register access
`timescale 1ns/1ps

// Overview of operation
// (R01) Full duplex: each bit out matched in
// (R02) Master selects slave low, releases high
// (R03) MOSI master-to-slave, MISO back, master clocks
// (R04) Master never drives select by itself
// (R05) Master write starts eight bits, sets flag
// (R06) Flag with enable raises interrupt request
// (R07) Next byte by rewrite; last byte kept
// (R08) Idle slave: MISO off, no shifting
// (R09) Slave sets flag after full byte
// (R10) Slave accepts new data, keeps received byte
// (R11) Transmit single buffered; no mid-byte writes
// (R12) Receive double buffered; unread byte overwritten
// (R13) External SCK phases exceed two cycles
// (R14) Enabled port forces pin directions; code only forces inputs off, outputs also need their pin-control enable bits
// (R15) Power-off bit holds port inactive
// (R16) Seven master rates including divide by two
// (R17) Order bit picks LSB or MSB first
// (R18) Write during transfer sets collision flag
// (R19) Completion interrupt can wake processor
// (R20) Slave select high resets shift logic
// (R21) Select low as master input: become slave
// (R22) Polarity and phase give four modes
// (R23) Divide by 4,16,64,128 or 2,8,32,64
// (R24) Data register: read receive, write transmit
module sms_port (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire sms_pkg::sms_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    // Serial pins
    input wire sms_pkg::sms_pin_in_s pin_in,
    output sms_pkg::sms_pin_out_s pin_out,
    // Processor side
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    output logic irq_req,
    output logic wake_req
);

    logic [7:0] serial_control_reg;
    logic [7:0] pin_ctl;
    logic serial_power_off_bit;
    logic double_rate_bit;
    logic transfer_done_flag;
    logic write_collision_flag;
    logic clear_armed;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] rx_buf;
    logic out_bit;
    logic [2:0] bit_cnt;
    logic [3:0] edge_idx;
    logic [6:0] div_cnt;
    logic sck_drv;
    sms_pkg::sms_mstate_e mstate;

    // Two-stage synchronisers plus one history stage for SCK edges
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic sck_hist;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
            sck_hist <= 1'b1;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            sck_hist <= pin_sync[3];
        end
    end

    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    assign sck_s = pin_sync[3];
    assign mosi_s = pin_sync[2];
    assign miso_s = pin_sync[1];
    assign ss_s = pin_sync[0];

    // Control fields
    logic irq_en;
    logic port_en;
    logic lsb_first;
    logic master_select_bit;
    logic cpol;
    logic cpha;
    logic [1:0] rate_select_bits;
    assign irq_en = serial_control_reg[sms_pkg::SMS_CTRL_IRQ_EN];
    assign port_en = serial_control_reg[sms_pkg::SMS_CTRL_ENABLE] & ~serial_power_off_bit; // R15
    assign lsb_first = serial_control_reg[sms_pkg::SMS_CTRL_ORDER];
    assign master_select_bit = serial_control_reg[sms_pkg::SMS_CTRL_MASTER];
    assign cpol = serial_control_reg[sms_pkg::SMS_CTRL_CPOL];
    assign cpha = serial_control_reg[sms_pkg::SMS_CTRL_CPHA];
    assign rate_select_bits = serial_control_reg[sms_pkg::SMS_CTRL_RATE_HI:sms_pkg::SMS_CTRL_RATE_LO];

    logic is_master;
    logic is_slave;
    logic slave_active;
    logic mode_fault;
    assign is_master = port_en & master_select_bit;
    assign is_slave = port_en & ~master_select_bit;
    assign slave_active = is_slave & ~ss_s; // R08
    // Another master pulled select low while select is an input
    assign mode_fault = is_master & ~pin_ctl[sms_pkg::SMS_PINS_SS_OE] & ~ss_s; // R21

    // Bus decode
    logic wr_ctrl;
    logic wr_stat;
    logic wr_data;
    logic wr_pins;
    logic wr_pwr;
    logic rd_stat;
    logic rd_data;
    assign wr_ctrl = bus_req.wr & (bus_req.addr == sms_pkg::SMS_OFS_CTRL);
    assign wr_stat = bus_req.wr & (bus_req.addr == sms_pkg::SMS_OFS_STAT);
    assign wr_data = bus_req.wr & (bus_req.addr == sms_pkg::SMS_OFS_DATA);
    assign wr_pins = bus_req.wr & (bus_req.addr == sms_pkg::SMS_OFS_PINS);
    assign wr_pwr = bus_req.wr & (bus_req.addr == sms_pkg::SMS_OFS_PWR);
    assign rd_stat = bus_req.rd & (bus_req.addr == sms_pkg::SMS_OFS_STAT);
    assign rd_data = bus_req.rd & (bus_req.addr == sms_pkg::SMS_OFS_DATA);

    // Edge events, master and slave share one shifter
    logic [6:0] half_div;
    logic m_tick;
    logic m_lead;
    logic m_trail;
    logic sck_rise;
    logic sck_fall;
    logic s_lead;
    logic s_trail;
    logic sample_ev;
    logic setup_ev;
    logic in_bit;
    logic [7:0] rx_next;
    logic busy;
    logic done_ev;
    logic wr_accept;
    logic wr_collide;

    assign half_div = sms_pkg::SMS_HALF_DIV[{double_rate_bit, rate_select_bits}]; // R16 R23
    assign m_tick = (mstate == sms_pkg::SMS_RUN) & (div_cnt == half_div - 7'h01);
    assign m_lead = m_tick & ~edge_idx[0];
    assign m_trail = m_tick & edge_idx[0];
    assign sck_rise = sck_s & ~sck_hist;
    assign sck_fall = ~sck_s & sck_hist;
    assign s_lead = slave_active & (cpol ? sck_fall : sck_rise); // R22
    assign s_trail = slave_active & (cpol ? sck_rise : sck_fall);
    assign sample_ev = cpha ? (m_trail | s_trail) : (m_lead | s_lead); // R22
    assign setup_ev = cpha ? (m_lead | s_lead) : (m_trail | s_trail);
    // Master reads MISO straight from the pin: it answers our own SCK, and two
    // synchroniser stages would cost a whole bit at the divide-by-two rate
    assign in_bit = is_master ? pin_in.miso : mosi_s; // R03
    // With sampling on the leading edge the byte is already complete at the last edge
    assign rx_next = sample_ev ? next_shreg : shreg;
    assign busy = (mstate == sms_pkg::SMS_RUN) | (slave_active & (bit_cnt != 3'h0));
    assign wr_accept = wr_data & ~busy & port_en;
    assign wr_collide = wr_data & busy; // R18
    assign done_ev = (m_tick & (edge_idx == sms_pkg::SMS_LAST_EDGE))
                   | (is_slave & sample_ev & (bit_cnt == sms_pkg::SMS_LAST_BIT)); // R05 R09

    // Incoming bit enters at the end opposite the one the outgoing bit leaves from
    always_comb begin
        if (lsb_first) begin // R17
            next_shreg = {in_bit, shreg[7:1]}; // R01
        end else begin
            next_shreg = {shreg[6:0], in_bit}; // R01
        end
    end

    // Control register; master bit drops on a mode fault
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serial_control_reg <= sms_pkg::SMS_CTRL_RST;
        end else if (mode_fault) begin
            serial_control_reg[sms_pkg::SMS_CTRL_MASTER] <= 1'b0; // R21
        end else if (wr_ctrl) begin
            serial_control_reg <= bus_req.wdata;
        end
    end

    // Status, pin and power registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            double_rate_bit <= 1'b0;
            pin_ctl <= sms_pkg::SMS_PINS_RST;
            serial_power_off_bit <= 1'b0;
        end else begin
            if (wr_stat) begin
                double_rate_bit <= bus_req.wdata[sms_pkg::SMS_STAT_DOUBLE];
            end
            if (wr_pins) begin
                pin_ctl <= bus_req.wdata;
            end
            if (wr_pwr) begin
                serial_power_off_bit <= bus_req.wdata[sms_pkg::SMS_PWR_OFF];
            end
        end
    end

    // Flags clear by status read with flag set, then a data access; a new event wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            transfer_done_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            clear_armed <= 1'b0;
        end else begin
            if (rd_stat) begin
                clear_armed <= transfer_done_flag | write_collision_flag;
            end else if (rd_data | wr_data) begin
                clear_armed <= 1'b0;
            end
            if (done_ev | mode_fault) begin
                transfer_done_flag <= 1'b1; // R05 R09 R21
            end else if ((clear_armed & (rd_data | wr_data)) | irq_ack) begin
                transfer_done_flag <= 1'b0;
            end
            if (wr_collide) begin
                write_collision_flag <= 1'b1; // R18
            end else if (clear_armed & (rd_data | wr_data)) begin
                write_collision_flag <= 1'b0;
            end
        end
    end

    // Master clock generator
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mstate <= sms_pkg::SMS_IDLE;
            div_cnt <= 7'h00;
            edge_idx <= 4'h0;
            sck_drv <= 1'b0;
        end else begin
            case (mstate)
                sms_pkg::SMS_IDLE: begin
                    sck_drv <= cpol; // R22
                    div_cnt <= 7'h00;
                    edge_idx <= 4'h0;
                    if (wr_accept & is_master) begin
                        mstate <= sms_pkg::SMS_RUN; // R05 R07
                    end
                end
                sms_pkg::SMS_RUN: begin
                    if (~is_master) begin
                        mstate <= sms_pkg::SMS_IDLE; // R15 R21
                    end else if (m_tick) begin
                        div_cnt <= 7'h00;
                        sck_drv <= ~sck_drv;
                        edge_idx <= edge_idx + 4'h1;
                        if (edge_idx == sms_pkg::SMS_LAST_EDGE) begin
                            mstate <= sms_pkg::SMS_IDLE; // R05
                        end
                    end else begin
                        div_cnt <= div_cnt + 7'h01;
                    end
                end
                default: begin
                    mstate <= sms_pkg::SMS_IDLE;
                end
            endcase
        end
    end

    // Shift register, bit counter and data-out bit
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shreg <= sms_pkg::SMS_DATA_RST;
            bit_cnt <= 3'h0;
            out_bit <= 1'b0;
        end else if (wr_accept) begin
            shreg <= bus_req.wdata; // R24 R10
            bit_cnt <= 3'h0;
            out_bit <= lsb_first ? bus_req.wdata[0] : bus_req.wdata[7]; // R17
        end else if (is_slave & ss_s) begin
            bit_cnt <= 3'h0; // R20
            out_bit <= lsb_first ? shreg[0] : shreg[7];
        end else if (~port_en) begin
            bit_cnt <= 3'h0; // R15
        end else begin
            if (sample_ev) begin
                shreg <= next_shreg;
                bit_cnt <= bit_cnt + 3'h1;
            end
            if (setup_ev) begin
                out_bit <= lsb_first ? shreg[0] : shreg[7]; // R22
            end
        end
    end

    // Receive buffer: overwritten if software is late
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_buf <= sms_pkg::SMS_DATA_RST;
        end else if (done_ev) begin
            rx_buf <= rx_next; // R07 R12
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                sms_pkg::SMS_OFS_CTRL: bus_rdata <= serial_control_reg;
                sms_pkg::SMS_OFS_STAT: bus_rdata <= {transfer_done_flag, write_collision_flag, 5'h00, double_rate_bit};
                sms_pkg::SMS_OFS_DATA: bus_rdata <= rx_buf; // R24
                sms_pkg::SMS_OFS_PINS: bus_rdata <= pin_ctl;
                sms_pkg::SMS_OFS_PWR: bus_rdata <= {7'h00, serial_power_off_bit};
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // Wake source from idle sleep is the flag with enable, not gated by the global interrupt enable
    assign irq_req = transfer_done_flag & irq_en & global_irq_enable; // R06
    assign wake_req = transfer_done_flag & irq_en; // R19

    // Pin overrides; select level is only what software sets
    always_comb begin
        pin_out.sck_o = sck_drv;
        pin_out.mosi_o = out_bit; // R03
        pin_out.miso_o = out_bit;
        pin_out.ss_n_o = pin_ctl[sms_pkg::SMS_PINS_SS_LEVEL]; // R04 R02
        pin_out.sck_oe = is_master & pin_ctl[sms_pkg::SMS_PINS_SCK_OE]; // R14
        pin_out.mosi_oe = is_master & pin_ctl[sms_pkg::SMS_PINS_MOSI_OE];
        pin_out.ss_n_oe = is_master & pin_ctl[sms_pkg::SMS_PINS_SS_OE];
        pin_out.miso_oe = slave_active & pin_ctl[sms_pkg::SMS_PINS_MISO_OE]; // R08
    end

    // Checks
    sequence s_master_start;
        wr_data && !busy && is_master;
    endsequence

    sequence s_running;
        mstate == sms_pkg::SMS_RUN;
    endsequence

    property p_master_start;
        @(posedge clk_sys) disable iff (reset)
        s_master_start |=> s_running;
    endproperty
    a_master_start: assert property (p_master_start) else $error("master write did not start clock"); // R05

    property p_done_flag;
        @(posedge clk_sys) disable iff (reset)
        (m_tick && edge_idx == 4'hf && is_master) |=> transfer_done_flag && mstate == sms_pkg::SMS_IDLE;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("flag not set after sixteenth edge"); // R05

    property p_irq;
        @(posedge clk_sys) disable iff (reset)
        (transfer_done_flag && irq_en && global_irq_enable) |-> irq_req && wake_req;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request missing"); // R06

    property p_idle_slave;
        @(posedge clk_sys) disable iff (reset)
        (is_slave && ss_s) |-> !pin_out.miso_oe ##1 (bit_cnt == 3'h0);
    endproperty
    a_idle_slave: assert property (p_idle_slave) else $error("idle slave drove or shifted"); // R08

    property p_collision;
        @(posedge clk_sys) disable iff (reset)
        (wr_data && busy && !wr_accept) |=> write_collision_flag && (shreg != $past(bus_req.wdata) || $stable(shreg));
    endproperty
    a_collision: assert property (p_collision) else $error("collision not flagged"); // R18

    property p_rx_keep;
        @(posedge clk_sys) disable iff (reset)
        (wr_accept && !done_ev) |=> $stable(rx_buf);
    endproperty
    a_rx_keep: assert property (p_rx_keep) else $error("receive byte disturbed by write"); // R10

    property p_rx_load;
        @(posedge clk_sys) disable iff (reset)
        done_ev |=> rx_buf == $past(rx_next);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("receive buffer not loaded"); // R12

    property p_power;
        @(posedge clk_sys) disable iff (reset)
        serial_power_off_bit |=> !is_master && !pin_out.sck_oe && !pin_out.miso_oe;
    endproperty
    a_power: assert property (p_power) else $error("port active while powered off"); // R15

    property p_mode_fault;
        @(posedge clk_sys) disable iff (reset)
        mode_fault |=> !master_select_bit && transfer_done_flag ##1 mstate == sms_pkg::SMS_IDLE;
    endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("select low did not force slave"); // R21

    property p_master_dirs;
        @(posedge clk_sys) disable iff (reset)
        is_master |-> !pin_out.miso_oe;
    endproperty
    a_master_dirs: assert property (p_master_dirs) else $error("master drove MISO"); // R14

endmodule

// >>> test/sms_slave_model.sv
// Behavioural external slave on the far side of the serial pins
`timescale 1ns/1ps
module sms_slave_model (
    // Pins
    input wire logic sck,
    input wire logic mosi,
    input wire logic ss_n,
    output logic miso,
    // Set-up and data
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic [7:0] tx,
    output logic [7:0] rx
);
    logic [7:0] sh;
    int k;
    function automatic logic pick(input int n);
        return lsb ? tx[n] : tx[7-n];
    endfunction
    initial begin
        miso = 1'b0;
        rx = 8'h00;
        sh = 8'h00;
        k = 0;
    end
    // Released line has no pull, so never leave the last bit showing
    always @(posedge ss_n) miso = ~miso;
    always @(negedge ss_n) begin
        k = 0;
        if (!cpha) begin
            miso = pick(0);
            k = 1;
        end
    end
    always @(sck) begin
        if (!ss_n) begin
            if ((sck != cpol) != cpha) begin
                sh = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
                rx = sh;
            end else if (k < 8) begin
                miso = pick(k);
                k++;
            end
        end
    end
endmodule

// >>> test/tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    sms_pkg::sms_bus_req_s req = '0;
    logic [7:0] bus_rdata;
    sms_pkg::sms_pin_in_s pin_in;
    sms_pkg::sms_pin_out_s pin_out;
    logic glob = 1'b0;
    logic irq_ack = 1'b0;
    logic irq_req;
    logic wake_req;
    logic m_sck = 1'b0;
    logic m_mosi = 1'b0;
    logic m_ss = 1'b1;
    logic s_miso;
    logic p_cpol = 1'b0;
    logic p_cpha = 1'b0;
    logic p_lsb = 1'b0;
    logic [7:0] p_tx = 8'h00;
    logic [7:0] p_rx;
    int fails = 0;
    int samples_checked = 0;
    int tog = 0;
    int gap = 0;
    int gmin = 999;
    int gmax = 0;
    logic psck = 1'b0;
    logic [7:0] v;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] g;

    always #12.5 clk_sys = ~clk_sys;

    // Driving end wins the wire, else the bench master or the far slave
    assign pin_in.sck = pin_out.sck_oe ? pin_out.sck_o : m_sck;
    assign pin_in.mosi = pin_out.mosi_oe ? pin_out.mosi_o : m_mosi;
    assign pin_in.miso = pin_out.miso_oe ? pin_out.miso_o : s_miso;
    assign pin_in.ss_n = pin_out.ss_n_oe ? pin_out.ss_n_o : m_ss;

    sms_port uut (.clk_sys(clk_sys), .reset(reset), .bus_req(req), .bus_rdata(bus_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .global_irq_enable(glob), .irq_ack(irq_ack), .irq_req(irq_req), .wake_req(wake_req));
    sms_slave_model far (.sck(pin_in.sck), .mosi(pin_in.mosi), .ss_n(pin_in.ss_n), .miso(s_miso),
        .cpol(p_cpol), .cpha(p_cpha), .lsb(p_lsb), .tx(p_tx), .rx(p_rx));

    // Toggle count and spacing of the master clock
    always @(posedge clk_sys) begin
        gap++;
        if (pin_out.sck_o !== psck) begin
            tog++;
            if (tog > 1 && gap < gmin) gmin = gap;
            if (tog > 1 && gap > gmax) gmax = gap;
            gap = 0;
        end
        psck = pin_out.sck_o;
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] dd);
        @(posedge clk_sys);
        req.addr <= a;
        req.wdata <= dd;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] dd);
        @(posedge clk_sys);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 dd = bus_rdata;
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        v = 8'h00;
        while (v[7] !== 1'b1 && n < 3000) begin
            rd(sms_pkg::SMS_OFS_STAT, v);
            n++;
        end
        if (v[7] !== 1'b1) begin
            fails++;
            final_report();
        end
    endtask

    // Half period in system cycles: double speed halves every divisor
    function automatic logic [7:0] half(input logic dbl, input logic [1:0] r);
        logic [7:0] t [4];
        t = '{8'h02, 8'h08, 8'h20, 8'h40};
        return dbl ? t[r] >> 1 : t[r];
    endfunction

    // Set up with the far slave released, then select it
    task automatic cfg(input logic [7:0] cc, input logic dbl, input logic [7:0] sd);
        wr(sms_pkg::SMS_OFS_PINS, 8'h17);
        wr(sms_pkg::SMS_OFS_STAT, {7'h00, dbl});
        wr(sms_pkg::SMS_OFS_CTRL, cc);
        p_cpol = cc[3];
        p_cpha = cc[2];
        p_lsb = cc[5];
        p_tx = sd;
        wr(sms_pkg::SMS_OFS_PINS, 8'h07);
        #1;
        tog = 0;
        gmin = 999;
        gmax = 0;
    endtask

    task automatic xfer(input logic [7:0] cc, input logic dbl, input logic [7:0] dd, input logic [7:0] sd);
        cfg(cc, dbl, sd);
        wr(sms_pkg::SMS_OFS_DATA, dd);
        chk("pin_oe", 8'h06, {5'h00, pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe});
        wait_done();
        chk("irq_req", {7'h00, cc[7] & glob}, {7'h00, irq_req});
        chk("wake_req", {7'h00, cc[7]}, {7'h00, wake_req});
        chk("sck_toggles", 8'h10, tog[7:0]);
        chk("half_min", half(dbl, cc[1:0]), gmin[7:0]);
        chk("half_max", half(dbl, cc[1:0]), gmax[7:0]);
        rd(sms_pkg::SMS_OFS_DATA, v);
        chk("rx_byte", sd, v);
        chk("far_rx", dd, p_rx);
        wr(sms_pkg::SMS_OFS_PINS, 8'h17);
    endtask

    // Bench as master, mode 0, most significant bit first
    task automatic sbits(input logic [7:0] dd, input int n, output logic [7:0] gg);
        gg = 8'h00;
        for (int b = 7; b > 7 - n; b--) begin
            @(posedge clk_sys);
            m_mosi <= dd[b];
            repeat (6) @(posedge clk_sys);
            gg[b] = pin_in.miso;
            m_sck <= 1'b1;
            repeat (6) @(posedge clk_sys);
            m_sck <= 1'b0;
        end
    endtask

    initial begin
        void'($urandom(32'hb028));
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        rd(sms_pkg::SMS_OFS_CTRL, v);
        chk("ctrl_reset", 8'h00, v);
        rd(sms_pkg::SMS_OFS_PINS, v);
        chk("pins_reset", 8'h10, v);
        rd(3'h5, v);
        chk("unmapped", 8'h00, v);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            glob <= 1'($urandom);
            c = {1'($urandom), 1'b1, 1'($urandom), 1'b1, i[0], i[1] ^ i[2], i[1:0]};
            xfer(c, i[2], 8'($urandom), 8'($urandom));
        end
        // Rewrite mid-byte is refused and flagged
        cfg(8'hd1, 1'b0, 8'hc3);
        wr(sms_pkg::SMS_OFS_DATA, 8'ha5);
        wr(sms_pkg::SMS_OFS_DATA, 8'h5a);
        rd(sms_pkg::SMS_OFS_STAT, v);
        chk("write_collision_flag", 8'h40, v & 8'h40);
        wait_done();
        @(posedge clk_sys);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        #1;
        chk("wake_after_ack", 8'h00, {7'h00, wake_req});
        rd(sms_pkg::SMS_OFS_DATA, v);
        chk("rx_after_write_collision_flag", 8'hc3, v);
        chk("far_rx_first", 8'ha5, p_rx);
        // Select pulled low from outside while master
        wr(sms_pkg::SMS_OFS_CTRL, 8'h50);
        wr(sms_pkg::SMS_OFS_PINS, 8'h03);
        @(posedge clk_sys);
        m_ss <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd(sms_pkg::SMS_OFS_STAT, v);
        chk("fault_flag", 8'h80, v & 8'h80);
        rd(sms_pkg::SMS_OFS_CTRL, v);
        chk("fault_ctrl", 8'h40, v);
        // Slave, first unselected
        @(posedge clk_sys);
        m_ss <= 1'b1;
        wr(sms_pkg::SMS_OFS_PINS, 8'h08);
        wr(sms_pkg::SMS_OFS_DATA, 8'h3c);
        sbits(8'hff, 8, g);
        rd(sms_pkg::SMS_OFS_STAT, v);
        chk("idle_flag", 8'h00, v & 8'h80);
        chk("idle_miso_oe", 8'h00, {7'h00, pin_out.miso_oe});
        @(posedge clk_sys);
        m_ss <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("slave_oe", 8'h01, {5'h00, pin_out.sck_oe, pin_out.mosi_oe, pin_out.miso_oe});
        d = 8'($urandom);
        sbits(d, 8, g);
        chk("slave_tx", 8'h3c, g);
        rd(sms_pkg::SMS_OFS_STAT, v);
        chk("slave_flag", 8'h80, v & 8'h80);
        wr(sms_pkg::SMS_OFS_DATA, 8'h96);
        rd(sms_pkg::SMS_OFS_DATA, v);
        chk("slave_rx", d, v);
        // Partial byte dropped by deselect, then an unread byte overwritten
        sbits(8'h0f, 4, g);
        @(posedge clk_sys);
        m_ss <= 1'b1;
        repeat (6) @(posedge clk_sys);
        m_ss <= 1'b0;
        repeat (6) @(posedge clk_sys);
        sbits(8'h11, 8, g);
        d = 8'($urandom);
        sbits(d, 8, g);
        rd(sms_pkg::SMS_OFS_DATA, v);
        chk("rx_overrun", d, v);
        // Powered down: a data write must not clock anything
        @(posedge clk_sys);
        m_ss <= 1'b1;
        wr(sms_pkg::SMS_OFS_PWR, 8'h01);
        cfg(8'h50, 1'b1, 8'h00);
        wr(sms_pkg::SMS_OFS_DATA, 8'h55);
        repeat (100) @(posedge clk_sys);
        chk("off_toggles", 8'h00, tog[7:0]);
        final_report();
    end
endmodule
